// ---- fieldbus_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model #(parameter int TICK_PER = 8) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    output logic cycle_tick_o
);
    int cnt;
    // Cycle shortened far below the real minimum so the run stays short
    always_ff @(posedge clk_i) begin
        cnt <= (sys_rst_i || cnt == TICK_PER - 1) ? 0 : cnt + 1;
        cycle_tick_o <= !sys_rst_i && cnt == TICK_PER - 1;
    end
endmodule
`default_nettype wire

// ---- od_tuning_store.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "profile_setpoint_defines.svh"

module od_tuning_store (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic we_i,
    input wire logic [2:0] slot_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);

    profile_setpoint_pkg::store_state_t s_q;
    profile_setpoint_pkg::store_state_t s_d;
    logic [4:0][15:0] rst_words;

    // ************************************************************
    // Per-slot reset values
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < `NUM_SLOTS; g = g + 1) begin : g_rst
            assign rst_words[g] = (g == `SLOT_PROP) ? `PROP_RST :
                                  (g == `SLOT_INT) ? `INT_RST : `TUNE_RST;
        end
    endgenerate

    always_comb begin
        s_d = s_q;
        // Read returns the old word when the same slot is written
        s_d.rdata = s_q.word[slot_i];
        if (we_i) begin
            s_d.word[slot_i] = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q.word <= rst_words;
            s_q.rdata <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o = s_q.rdata;

endmodule
`default_nettype wire

// ---- profile_setpoint_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module profile_setpoint_chk (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic od_wr_i,
    input wire logic od_rd_i,
    input wire logic [15:0] od_index_i,
    input wire logic [31:0] od_wdata_i,
    input wire logic od_ack_o,
    input wire logic od_err_o,
    input wire logic cycle_tick_i,
    input wire logic [15:0] status_word_o,
    input wire logic move_start_o,
    input wire logic [15:0] fwd_torque_limit_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wr_ack_a: assert property (od_wr_i |=> od_ack_o) else $error("write unanswered");
    rd_ack_a: assert property (od_rd_i |=> !od_ack_o ##1 od_ack_o) else $error("read late");
    err_ack_a: assert property (od_err_o |-> od_ack_o) else $error("abort alone");
    torque_range_a: assert property (od_wr_i && od_index_i == 16'h60e0 &&
        od_wdata_i > 32'd5000 |=> od_err_o) else $error("torque not refused");
    // The forward torque limit may only move as the answer to a write of its own object
    torque_hold_a: assert property (!$stable(fwd_torque_limit_o) |->
        $past(od_wr_i) && $past(od_index_i) == 16'h60e0) else $error("torque moved");
    start_ack_a: assert property (move_start_o |-> status_word_o[12]) else $error("no ack");
    start_tick_a: assert property (move_start_o |-> $past(cycle_tick_i)) else $error("no tick");
    ack_clear_a: assert property ($fell(status_word_o[12]) |-> $past(cycle_tick_i))
        else $error("ack cleared off tick");
    spare_bits_a: assert property ((status_word_o & 16'hebd8) == 16'h0000)
        else $error("spare status bit");
    cover property (move_start_o);
    cover property ($fell(status_word_o[12]));
    cover property (od_err_o);
endmodule
bind profile_setpoint_handshake profile_setpoint_chk i_chk (.clk_i, .sys_rst_i, .od_wr_i,
    .od_rd_i, .od_index_i, .od_wdata_i, .od_ack_o, .od_err_o, .cycle_tick_i, .status_word_o,
    .move_start_o, .fwd_torque_limit_o);
`default_nettype wire

// ---- profile_setpoint_defines.svh ----
`ifndef PROFILE_SETPOINT_DEFINES_SVH
`define PROFILE_SETPOINT_DEFINES_SVH

// ************************************************************
// Object dictionary indexes and subindexes
// ************************************************************
`define IDX_CTRL_WORD 16'h6040
`define IDX_MODE_SEL 16'h6060
`define IDX_SPEED_CEIL 16'h607f
`define IDX_CMD_SPEED 16'h60ff
`define IDX_FWD_TORQUE 16'h60e0
`define IDX_REV_TORQUE 16'h60e1
`define IDX_SPEED_TUNE 16'h2006
`define IDX_TORQUE_TUNE 16'h2007
`define SUB_MAIN 8'h00
`define SUB_PROP_GAIN 8'h01
`define SUB_INT_GAIN 8'h02
`define SUB_FF_GAIN 8'h0a
`define SUB_TQ_FILT 8'h03
`define SUB_FF_FILT 8'h08

// ************************************************************
// Tuning store slots
// ************************************************************
`define SLOT_PROP 3'h0
`define SLOT_INT 3'h1
`define SLOT_FF_GAIN 3'h2
`define SLOT_TQ_FILT 3'h3
`define SLOT_FF_FILT 3'h4
`define NUM_SLOTS 5

// ************************************************************
// Command word and status word bit positions
// ************************************************************
`define CW_READY 0
`define CW_MAIN_ON 1
`define CW_QSTOP_N 2
`define CW_OP_EN 3
`define CW_NEW_SP 4
`define CW_RELATIVE 6
`define CW_HALT 8
`define SW_READY 0
`define SW_MAIN_ON 1
`define SW_OP_EN 2
`define SW_QSTOP_N 5
`define SW_REACHED 10
`define SW_SP_ACK 12

// ************************************************************
// Mode codes and accepted ranges
// ************************************************************
`define MODE_PP 8'h01
`define MODE_PV 8'h03
`define MODE_CSP 8'h08
`define MODE_MAX 8'h0a
`define TORQUE_MAX 16'h1388
`define PROP_MIN 16'h0001
`define PROP_MAX 16'h4e20
`define INT_MIN 16'h000f
`define INT_MAX 16'hc800
`define FF_GAIN_MAX 16'h07d0
`define TQ_FILT_MAX 16'h0bb8
`define FF_FILT_MAX 16'h1900

// ************************************************************
// Reset values
// ************************************************************
`define CTRL_RST 16'h0000
`define MODE_RST 8'h00
`define CEIL_RST 32'h7fffffff
`define SPEED_RST 32'h00000000
`define TORQUE_RST 16'h1388
`define PROP_RST 16'h0064
`define INT_RST 16'h07d0
`define TUNE_RST 16'h0000

`endif

// ---- profile_setpoint_handshake.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "profile_setpoint_defines.svh"

module profile_setpoint_handshake (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic od_wr_i,
    input wire logic od_rd_i,
    input wire logic [15:0] od_index_i,
    input wire logic [7:0] od_subindex_i,
    input wire logic [31:0] od_wdata_i,
    output logic [31:0] od_rdata_o,
    output logic od_ack_o,
    output logic od_err_o,
    input wire logic cycle_tick_i,
    input wire logic [31:0] target_position_i,
    input wire logic [31:0] profile_speed_i,
    input wire logic [31:0] profile_accel_i,
    input wire logic [31:0] profile_decel_i,
    input wire logic [31:0] actual_position_i,
    input wire logic [31:0] actual_speed_i,
    input wire logic [31:0] motor_max_speed_i,
    input wire logic [15:0] position_window_i,
    input wire logic [15:0] velocity_window_i,
    input wire logic [15:0] window_time_i,
    output logic [15:0] status_word_o,
    output logic [7:0] mode_display_o,
    output logic [31:0] position_goal_o,
    output logic move_start_o,
    output logic [31:0] move_speed_o,
    output logic [31:0] move_accel_o,
    output logic [31:0] move_decel_o,
    output logic [31:0] speed_ref_o,
    output logic [15:0] fwd_torque_limit_o,
    output logic [15:0] rev_torque_limit_o,
    output logic halt_o
);

    profile_setpoint_pkg::hs_state_t s_q;
    profile_setpoint_pkg::hs_state_t s_d;
    logic mem_we;
    logic [2:0] mem_slot;
    logic [15:0] mem_rdata;

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] abs_diff(input logic signed [31:0] a,
                                             input logic signed [31:0] b);
        logic signed [32:0] d;
        d = 33'(a) - 33'(b);
        abs_diff = d[32] ? 32'(-d) : d[31:0];
    endfunction

    // Tuning objects share one decode for reads and writes
    function automatic logic [3:0] tune_slot(input logic [15:0] idx, input logic [7:0] sub);
        tune_slot = 4'h0;
        if (idx == `IDX_SPEED_TUNE) begin
            case (sub)
                `SUB_PROP_GAIN: tune_slot = {1'b1, `SLOT_PROP};
                `SUB_INT_GAIN: tune_slot = {1'b1, `SLOT_INT};
                `SUB_FF_GAIN: tune_slot = {1'b1, `SLOT_FF_GAIN};
                default: tune_slot = 4'h0;
            endcase
        end else if (idx == `IDX_TORQUE_TUNE) begin
            case (sub)
                `SUB_TQ_FILT: tune_slot = {1'b1, `SLOT_TQ_FILT};
                `SUB_FF_FILT: tune_slot = {1'b1, `SLOT_FF_FILT};
                default: tune_slot = 4'h0;
            endcase
        end
    endfunction

    function automatic logic tune_ok(input logic [2:0] slot, input logic [31:0] v);
        case (slot)
            `SLOT_PROP: tune_ok = v >= 32'(`PROP_MIN) && v <= 32'(`PROP_MAX);
            `SLOT_INT: tune_ok = v >= 32'(`INT_MIN) && v <= 32'(`INT_MAX);
            `SLOT_FF_GAIN: tune_ok = v <= 32'(`FF_GAIN_MAX);
            `SLOT_TQ_FILT: tune_ok = v <= 32'(`TQ_FILT_MAX);
            `SLOT_FF_FILT: tune_ok = v <= 32'(`FF_FILT_MAX);
            default: tune_ok = 1'b0;
        endcase
    endfunction

    // A zero ceiling is honoured and holds the motor still
    function automatic logic [31:0] clamp_speed(input logic signed [31:0] v,
                                                input logic [31:0] ceil,
                                                input logic [31:0] motor);
        logic [31:0] lim;
        lim = (ceil < motor) ? ceil : motor;
        if (lim[31]) begin
            lim = 32'h7fffffff;
        end
        if (v >= 0 && v > $signed(lim)) begin
            clamp_speed = lim;
        end else if (v < 0 && abs_diff(v, 32'sh0) > lim) begin
            clamp_speed = 32'(-lim);
        end else begin
            clamp_speed = v;
        end
    endfunction

    // One step of the speed trajectory; accel away from zero except when leaving zero downward, decel toward it
    function automatic logic [31:0] ramp(input logic signed [31:0] cur,
                                         input logic signed [31:0] tgt,
                                         input logic [31:0] up,
                                         input logic [31:0] dn);
        logic [31:0] gap;
        logic [31:0] rate;
        logic away;
        gap = abs_diff(tgt, cur);
        away = (cur >= 0) ? (tgt > cur) : (tgt < cur);
        rate = away ? up : dn;
        if (gap <= rate) begin
            ramp = tgt;
        end else if (tgt > cur) begin
            ramp = cur + rate;
        end else begin
            ramp = cur - rate;
        end
    endfunction

    // ************************************************************
    // Next-state logic
    // ************************************************************
    logic started;
    logic sp_edge;
    logic [3:0] slot_hit;
    logic [31:0] pv_target;

    always_comb begin
        s_d = s_q;
        s_d.move_start = 1'b0;
        s_d.od_ack = 1'b0;
        s_d.od_err = 1'b0;
        s_d.rd_pend = 1'b0;
        mem_we = 1'b0;
        slot_hit = tune_slot(od_index_i, od_subindex_i);
        mem_slot = slot_hit[2:0];
        started = s_q.ctrl[`CW_READY] & s_q.ctrl[`CW_MAIN_ON] &
                  s_q.ctrl[`CW_QSTOP_N] & s_q.ctrl[`CW_OP_EN];
        sp_edge = s_q.ctrl[`CW_NEW_SP] & ~s_q.sp_prev;
        pv_target = s_q.ctrl[`CW_HALT] ? 32'h00000000 :
                    clamp_speed(s_q.cmd_speed, s_q.ceil, motor_max_speed_i);

        // Object dictionary writes
        if (od_wr_i) begin
            s_d.od_ack = 1'b1;
            if (od_subindex_i == `SUB_MAIN && od_index_i == `IDX_CTRL_WORD) begin
                s_d.ctrl = od_wdata_i[15:0];
            end else if (od_subindex_i == `SUB_MAIN && od_index_i == `IDX_MODE_SEL) begin
                if (od_wdata_i[7:0] <= `MODE_MAX) begin
                    s_d.mode_req = od_wdata_i[7:0];
                end else begin
                    s_d.od_err = 1'b1;
                end
            end else if (od_subindex_i == `SUB_MAIN && od_index_i == `IDX_SPEED_CEIL) begin
                s_d.ceil = od_wdata_i;
            end else if (od_subindex_i == `SUB_MAIN && od_index_i == `IDX_CMD_SPEED) begin
                s_d.cmd_speed = od_wdata_i;
            end else if (od_subindex_i == `SUB_MAIN && od_index_i == `IDX_FWD_TORQUE) begin
                if (od_wdata_i <= 32'(`TORQUE_MAX)) begin
                    s_d.fwd_tq = od_wdata_i[15:0];
                end else begin
                    s_d.od_err = 1'b1;
                end
            end else if (od_subindex_i == `SUB_MAIN && od_index_i == `IDX_REV_TORQUE) begin
                if (od_wdata_i <= 32'(`TORQUE_MAX)) begin
                    s_d.rev_tq = od_wdata_i[15:0];
                end else begin
                    s_d.od_err = 1'b1;
                end
            end else if (slot_hit[3] && tune_ok(slot_hit[2:0], od_wdata_i)) begin
                mem_we = 1'b1;
            end else begin
                s_d.od_err = 1'b1;
            end
        end else if (od_rd_i) begin
            // Answer comes a cycle later so tuning words can leave the store
            s_d.rd_pend = 1'b1;
            s_d.rd_mem = slot_hit[3];
            s_d.rd_local = 32'h00000000;
            if (od_subindex_i != `SUB_MAIN) begin
                s_d.rd_local = 32'h00000000;
            end else if (od_index_i == `IDX_CTRL_WORD) begin
                s_d.rd_local = {16'h0000, s_q.ctrl};
            end else if (od_index_i == `IDX_MODE_SEL) begin
                s_d.rd_local = {24'h000000, s_q.mode_req};
            end else if (od_index_i == `IDX_SPEED_CEIL) begin
                s_d.rd_local = s_q.ceil;
            end else if (od_index_i == `IDX_CMD_SPEED) begin
                s_d.rd_local = s_q.cmd_speed;
            end else if (od_index_i == `IDX_FWD_TORQUE) begin
                s_d.rd_local = {16'h0000, s_q.fwd_tq};
            end else if (od_index_i == `IDX_REV_TORQUE) begin
                s_d.rd_local = {16'h0000, s_q.rev_tq};
            end
        end
        if (s_q.rd_pend) begin
            s_d.od_ack = 1'b1;
            s_d.od_rdata = s_q.rd_mem ? {16'h0000, mem_rdata} : s_q.rd_local;
        end

        // ************************************************************
        // Motion sequencing, once per communication cycle
        // ************************************************************
        if (cycle_tick_i) begin
            s_d.sp_prev = s_q.ctrl[`CW_NEW_SP];
            case (s_q.st)
                profile_setpoint_pkg::ST_OFF: begin
                    s_d.speed_ref = 32'h00000000;
                    s_d.sp_ack = 1'b0;
                    s_d.reached = 1'b0;
                    s_d.dwell = 16'h0000;
                    if (started) begin
                        s_d.mode_act = s_q.mode_req;
                        s_d.goal = actual_position_i;
                        s_d.st = profile_setpoint_pkg::ST_RUN;
                    end
                end
                profile_setpoint_pkg::ST_RUN: begin
                    if (!started) begin
                        // Quick stop and disable both brake on the decel ramp
                        s_d.speed_ref = ramp(s_q.speed_ref, 32'sh0, profile_decel_i,
                                             profile_decel_i);
                        s_d.goal = actual_position_i;
                        if (s_q.speed_ref == 32'h00000000) begin
                            s_d.st = profile_setpoint_pkg::ST_OFF;
                        end
                    end else if (s_q.mode_req != s_q.mode_act) begin
                        if (s_q.mode_act == `MODE_PV) begin
                            s_d.st = profile_setpoint_pkg::ST_MODE_STOP;
                        end else begin
                            s_d.mode_act = s_q.mode_req;
                            s_d.goal = actual_position_i;
                            s_d.reached = 1'b0;
                            s_d.dwell = 16'h0000;
                        end
                    end else if (s_q.mode_act == `MODE_PP) begin
                        // A new edge always preempts the running move
                        if (sp_edge) begin
                            s_d.goal = s_q.ctrl[`CW_RELATIVE] ?
                                       actual_position_i + target_position_i :
                                       target_position_i;
                            s_d.pp_speed = clamp_speed(profile_speed_i, s_q.ceil,
                                                       motor_max_speed_i);
                            s_d.pp_accel = profile_accel_i;
                            s_d.pp_decel = profile_decel_i;
                            s_d.move_start = 1'b1;
                            s_d.sp_ack = 1'b1;
                            s_d.reached = 1'b0;
                            s_d.dwell = 16'h0000;
                        end else begin
                            if (s_q.sp_ack && !s_q.ctrl[`CW_NEW_SP]) begin
                                s_d.sp_ack = 1'b0;
                            end
                            if (abs_diff(actual_position_i, s_q.goal) <=
                                {16'h0000, position_window_i}) begin
                                if (s_q.dwell >= window_time_i) begin
                                    s_d.reached = 1'b1;
                                end else begin
                                    s_d.dwell = s_q.dwell + 16'h0001;
                                end
                            end else begin
                                s_d.dwell = 16'h0000;
                                s_d.reached = 1'b0;
                            end
                        end
                    end else if (s_q.mode_act == `MODE_CSP) begin
                        s_d.goal = target_position_i;
                        s_d.sp_ack = 1'b0;
                        s_d.reached = abs_diff(actual_position_i, target_position_i) <=
                                      {16'h0000, position_window_i};
                    end else if (s_q.mode_act == `MODE_PV) begin
                        s_d.speed_ref = ramp(s_q.speed_ref, pv_target, profile_accel_i,
                                             profile_decel_i);
                        if (abs_diff(actual_speed_i, pv_target) <=
                            {16'h0000, velocity_window_i}) begin
                            if (s_q.dwell >= window_time_i) begin
                                s_d.reached = 1'b1;
                            end else begin
                                s_d.dwell = s_q.dwell + 16'h0001;
                            end
                        end else begin
                            s_d.dwell = 16'h0000;
                            s_d.reached = 1'b0;
                        end
                    end
                end
                profile_setpoint_pkg::ST_MODE_STOP: begin
                    s_d.reached = 1'b0;
                    s_d.dwell = 16'h0000;
                    s_d.speed_ref = ramp(s_q.speed_ref, 32'sh0, profile_decel_i,
                                         profile_decel_i);
                    if (s_q.speed_ref == 32'h00000000 &&
                        abs_diff(actual_speed_i, 32'sh0) <= {16'h0000, velocity_window_i}) begin
                        s_d.mode_act = s_q.mode_req;
                        s_d.goal = actual_position_i;
                        s_d.st = started ? profile_setpoint_pkg::ST_RUN :
                                 profile_setpoint_pkg::ST_OFF;
                    end
                end
                default: begin
                    s_d.st = profile_setpoint_pkg::ST_OFF;
                end
            endcase
        end

        // ************************************************************
        // Status word image
        // ************************************************************
        s_d.status = 16'h0000;
        s_d.status[`SW_READY] = s_d.ctrl[`CW_READY];
        s_d.status[`SW_MAIN_ON] = s_d.ctrl[`CW_READY] & s_d.ctrl[`CW_MAIN_ON];
        s_d.status[`SW_OP_EN] = s_d.st == profile_setpoint_pkg::ST_RUN;
        s_d.status[`SW_QSTOP_N] = s_d.ctrl[`CW_QSTOP_N];
        s_d.status[`SW_REACHED] = s_d.reached;
        s_d.status[`SW_SP_ACK] = s_d.sp_ack;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.st <= profile_setpoint_pkg::ST_OFF;
            s_q.ctrl <= `CTRL_RST;
            s_q.mode_req <= `MODE_RST;
            s_q.mode_act <= `MODE_RST;
            s_q.ceil <= `CEIL_RST;
            s_q.cmd_speed <= `SPEED_RST;
            s_q.fwd_tq <= `TORQUE_RST;
            s_q.rev_tq <= `TORQUE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Tuning words
    // ************************************************************
    od_tuning_store u_store (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .we_i(mem_we),
        .slot_i(mem_slot),
        .wdata_i(od_wdata_i[15:0]),
        .rdata_o(mem_rdata)
    );

    assign od_rdata_o = s_q.od_rdata;
    assign od_ack_o = s_q.od_ack;
    assign od_err_o = s_q.od_err;
    assign status_word_o = s_q.status;
    assign mode_display_o = s_q.mode_act;
    assign position_goal_o = s_q.goal;
    assign move_start_o = s_q.move_start;
    assign move_speed_o = s_q.pp_speed;
    assign move_accel_o = s_q.pp_accel;
    assign move_decel_o = s_q.pp_decel;
    assign speed_ref_o = s_q.speed_ref;
    assign fwd_torque_limit_o = s_q.fwd_tq;
    assign rev_torque_limit_o = s_q.rev_tq;
    assign halt_o = s_q.ctrl[`CW_HALT] & (s_q.st == profile_setpoint_pkg::ST_RUN);

endmodule
`default_nettype wire

// ---- profile_setpoint_pkg.sv ----
package profile_setpoint_pkg;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RUN = 2'b01,
        ST_MODE_STOP = 2'b10
    } run_state_t;

    typedef struct packed {
        run_state_t st;
        logic [15:0] ctrl;
        logic [7:0] mode_req;
        logic [7:0] mode_act;
        logic [31:0] ceil;
        logic [31:0] cmd_speed;
        logic [15:0] fwd_tq;
        logic [15:0] rev_tq;
        logic sp_prev;
        logic sp_ack;
        logic [31:0] goal;
        logic [31:0] pp_speed;
        logic [31:0] pp_accel;
        logic [31:0] pp_decel;
        logic move_start;
        logic reached;
        logic [15:0] dwell;
        logic [31:0] speed_ref;
        logic [15:0] status;
        logic rd_pend;
        logic rd_mem;
        logic [31:0] rd_local;
        logic od_ack;
        logic od_err;
        logic [31:0] od_rdata;
    } hs_state_t;

    typedef struct packed {
        logic [4:0][15:0] word;
        logic [15:0] rdata;
    } store_state_t;

endpackage

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_i = 0, sys_rst_i = 1, od_wr_i = 0, od_rd_i = 0, cycle_tick_i, od_ack_o, od_err_o;
    logic move_start_o, halt_o;
    logic [15:0] rev_torque_limit_o;
    logic [31:0] move_accel_o, move_decel_o;
    logic [7:0] od_subindex_i = 0, mode_display_o;
    logic [15:0] od_index_i = 0, win = 16'h0003, status_word_o, fwd_torque_limit_o;
    logic [31:0] od_wdata_i = 0, target_position_i = 0, actual_position_i = 0, actual_speed_i = 0;
    logic [31:0] rate = 32'h3c, mmax = 32'h32, od_rdata_o, position_goal_o, move_speed_o, speed_ref_o;
    int mismatches = 0, total_checks = 0, cyc = 0;
    always #12.5 clk_i = ~clk_i;
    fieldbus_master_model #(.TICK_PER(8)) i_master (.clk_i, .sys_rst_i, .cycle_tick_o(cycle_tick_i));
    profile_setpoint_handshake i_dut (.clk_i, .sys_rst_i, .od_wr_i, .od_rd_i, .od_index_i,
        .od_subindex_i, .od_wdata_i, .od_rdata_o, .od_ack_o, .od_err_o, .cycle_tick_i,
        .target_position_i, .profile_speed_i(rate), .profile_accel_i(rate), .profile_decel_i(rate),
        .actual_position_i, .actual_speed_i, .motor_max_speed_i(mmax), .position_window_i(win),
        .velocity_window_i(win), .window_time_i(win), .status_word_o, .mode_display_o,
        .position_goal_o, .move_start_o, .move_speed_o, .move_accel_o, .move_decel_o,
        .speed_ref_o, .fwd_torque_limit_o, .rev_torque_limit_o, .halt_o);
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic e);
        @(posedge clk_i);
        od_wr_i <= 1;
        od_index_i <= i;
        od_subindex_i <= s;
        od_wdata_i <= d;
        @(posedge clk_i);
        od_wr_i <= 0;
        #1 chk({od_ack_o, od_err_o}, {1'b1, e});
    endtask
    task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
        @(posedge clk_i);
        od_rd_i <= 1;
        od_index_i <= i;
        od_subindex_i <= s;
        @(posedge clk_i);
        od_rd_i <= 0;
        @(posedge clk_i);
        #1 chk({od_ack_o, od_rdata_o}, {1'b1, x});
    endtask
    task automatic move(input logic [15:0] cw, input logic [31:0] t, input logic [31:0] g);
        @(posedge clk_i) target_position_i <= t;
        wr(16'h6040, 0, cw & 16'hffef, 0);
        repeat (10) @(posedge clk_i);
        wr(16'h6040, 0, cw, 0);
        for (int n = 0; n < 40 && move_start_o !== 1'b1; n++) @(posedge clk_i) #1;
        chk({move_start_o, status_word_o[12]}, 2'b11);
        chk(position_goal_o, g);
        wr(16'h6040, 0, cw & 16'hffef, 0);
        repeat (10) @(posedge clk_i);
        #1 chk(status_word_o[12], 0);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            test_done;
        end
    end
    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 0;
        @(posedge clk_i);
        #1 chk({status_word_o, fwd_torque_limit_o}, 32'h00001388);
        wr(16'h60e0, 0, 32'd5001, 1);
        rd(16'h60e0, 0, 32'd5000);
        wr(16'h60e0, 0, 0, 0);
        wr(16'h60e1, 0, 32'd5001, 1);
        chk(rev_torque_limit_o, 32'd5000);
        wr(16'h2006, 8'h01, 0, 1);
        wr(16'h2006, 8'h01, 32'd20000, 0);
        rd(16'h2006, 8'h01, 32'd20000);
        wr(16'h2006, 8'h02, 32'd14, 1);
        rd(16'h2006, 8'h02, 32'h7d0);
        wr(16'h6060, 0, 32'd11, 1);
        rd(16'h1234, 0, 0);
        wr(16'h6060, 0, 1, 0);
        move(16'h001f, 32'd700, 32'd700);
        chk(move_speed_o, mmax);
        chk({move_accel_o[15:0], move_decel_o[15:0]}, {rate[15:0], rate[15:0]});
        @(posedge clk_i) actual_position_i <= 32'd700;
        repeat (60) @(posedge clk_i);
        #1 chk(status_word_o[10], 1);
        move(16'h005f, 32'd20, 32'd720);
        // Preempts the relative move before it can settle
        move(16'h001f, 32'hfffffffb, 32'hfffffffb);
        wr(16'h6040, 0, 32'h000b, 0);
        repeat (4) @(posedge clk_i);
        #1 chk(status_word_o[5], 0);
        wr(16'h6040, 0, 32'h010f, 0);
        repeat (20) @(posedge clk_i);
        #1 chk({halt_o, status_word_o[2]}, 2'b11);
        wr(16'h6040, 0, 32'h000f, 0);
        wr(16'h6060, 0, 3, 0);
        wr(16'h60ff, 0, 32'd60, 0);
        @(posedge clk_i) actual_speed_i <= 32'd1000;
        repeat (40) @(posedge clk_i);
        #1 chk({speed_ref_o, status_word_o[10]}, {mmax, 1'b0});
        @(posedge clk_i) actual_speed_i <= 32'd50;
        repeat (40) @(posedge clk_i);
        #1 chk(status_word_o[10], 1);
        wr(16'h6060, 0, 1, 0);
        repeat (40) @(posedge clk_i);
        #1 chk(mode_display_o, 3);
        @(posedge clk_i) actual_speed_i <= 0;
        repeat (40) @(posedge clk_i);
        #1 chk(mode_display_o, 1);
        wr(16'h6060, 0, 8, 0);
        @(posedge clk_i) target_position_i <= 32'd99;
        repeat (20) @(posedge clk_i);
        #1 chk(position_goal_o, 32'd99);
        test_done;
    end
endmodule
`default_nettype wire
